// ### src/ebi_ctrl.sv
// Contract
// - Buffer direction is low for ROM, ISA and card reads, high for writes.
// - Buffer direction and enable only matter while such accesses run.
// - The active-low buffer enable is asserted in ROM, ISA and card cycles.
// - Buffer pins start to work only once the gate bit is cleared to 0.
// - After reset both buffer pins stay low until the gate bit clears.
// - Buffer enable is 1 in DRAM cycles and Hibernate, direction free.
// - Enable 0 with direction 0 on reads, enable 0 on writes too.
// - Bank selects are SDRAM chip selects or EDO row strobes.
// - SDRAM column and row strobes are driven for SDRAM only.
// - Byte pins are SDRAM byte masks or EDO column strobes.
// - An SDRAM clock output and a separate clock-enable output exist.
// - Four active-low ROM bank selects, banks 0 to 2 also usable as GPIO.
// - The memory read strobe is asserted for ROM and system-bus reads.
// - The memory write strobe is asserted for ROM, DRAM and bus writes.
// - ROM cycles put address bits 22..1 out, others bits 21..0.
// - The SDRAM clock runs at bus clock rate only during SDRAM access.
`timescale 1ns/1ps
`default_nettype none

module ebi_ctrl #(
  parameter int ROM_BANKS  = ebi_pkg::EBI_ROM_BANKS,
  parameter int GPIO_BANKS = ebi_pkg::EBI_GPIO_BANKS
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    req_valid,
  input  wire ebi_pkg::ebi_req_type    req,
  input  wire logic                    ext_buffer_gate_bit,
  input  wire logic                    mem_is_edo,
  input  wire ebi_pkg::ebi_sdram_type  sdram,
  input  wire ebi_pkg::ebi_edo_type    edo,
  input  wire logic [GPIO_BANKS-1:0]   rom_gpio_mode,
  input  wire logic [GPIO_BANKS-1:0]   gpio_out,
  input  wire logic [GPIO_BANKS-1:0]   gpio_drive,
  input  wire logic [GPIO_BANKS-1:0]   rom_bank_select_in,
  output logic [GPIO_BANKS-1:0]        gpio_in,
  output logic                         buffer_enable_n,
  output logic                         buffer_direction,
  output logic [ROM_BANKS-1:0]         rom_bank_select_n,
  output logic [ROM_BANKS-1:0]         rom_bank_select_oe_n,
  output logic                         mem_read_strobe_n,
  output logic                         mem_write_strobe_n,
  output logic [21:0]                  addr_pins,
  output logic [1:0]                   sdram_bank_select_n,
  output logic                         sdram_col_strobe_n,
  output logic                         sdram_row_strobe_n,
  output logic                         upper_byte_mask,
  output logic                         lower_byte_mask,
  output logic                         memory_clock_gate,
  output logic                         memory_clock_out
);

  ebi_pkg::ebi_buf_type        buf_state_r;
  ebi_pkg::ebi_buf_type        buf_state_nxt;
  logic                        rd_strobe_r;
  logic                        rd_strobe_nxt;
  logic                        wr_strobe_r;
  logic                        wr_strobe_nxt;
  logic [21:0]                 addr_r;
  logic [21:0]                 addr_nxt;
  logic [ROM_BANKS-1:0]        rom_sel_r;
  logic [ROM_BANKS-1:0]        rom_sel_nxt;
  logic [GPIO_BANKS-1:0]       gpio_in_r;
  logic [GPIO_BANKS-1:0]       gpio_in_nxt;
  logic [GPIO_BANKS-1:0]       gpio_sync1_r;
  logic [GPIO_BANKS-1:0]       gpio_sync2_r;
  logic [GPIO_BANKS-1:0]       gpio_sync3_r;
  logic [GPIO_BANKS-1:0]       gpio_agree;
  logic                        clk_run_r;
  ebi_pkg::ebi_mem_pins_type   mem_pins;

  wire is_rom   = req_valid && (req.kind == ebi_pkg::EBI_ACC_ROM);
  wire is_isa   = req_valid && (req.kind == ebi_pkg::EBI_ACC_ISA);
  wire is_card  = req_valid && (req.kind == ebi_pkg::EBI_ACC_CARD);
  wire is_dram  = req_valid && (req.kind == ebi_pkg::EBI_ACC_DRAM);
  wire is_slow  = is_rom || is_isa || is_card;
  wire is_bus   = is_isa || is_card;

  // Returns the active-low one-hot select for a ROM bank number.
  function automatic logic [ROM_BANKS-1:0] rom_onehot_n(
    input logic       active,
    input logic [1:0] bank
  );
    logic [ROM_BANKS-1:0] sel;
    sel = {ROM_BANKS{ebi_pkg::EBI_STROBE_IDLE}};
    if (active) begin
      sel[bank] = 1'b0;
    end
    return sel;
  endfunction : rom_onehot_n

  // Buffer state. The gate bit is a plain level from the ISA control
  // register; while it is set the buffer pins rest low, and a reset puts
  // them back there until software clears the bit again.
  always_comb begin
    buf_state_nxt = ebi_pkg::EBI_BUF_OFF;
    if (ext_buffer_gate_bit) begin
      buf_state_nxt = ebi_pkg::EBI_BUF_GATED;
    end else if (req.hibernate || is_dram || !is_slow) begin
      // DRAM traffic and Hibernate keep the slow side cut off.
      buf_state_nxt = ebi_pkg::EBI_BUF_OFF;
    end else if (req.write) begin
      buf_state_nxt = ebi_pkg::EBI_BUF_WRITE;
    end else begin
      buf_state_nxt = ebi_pkg::EBI_BUF_READ;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      buf_state_r <= ebi_pkg::EBI_BUF_GATED;
    end else begin
      buf_state_r <= buf_state_nxt;
    end
  end

  // Pin values per buffer state; both pins are a combinational decode of
  // the two state flip-flops, not flip-flop outputs of their own.
  always_comb begin
    case (buf_state_r)
      ebi_pkg::EBI_BUF_GATED: begin
        buffer_enable_n  = ebi_pkg::EBI_BUF_EN_RST;
        buffer_direction = ebi_pkg::EBI_BUF_DIR_RST;
      end
      ebi_pkg::EBI_BUF_READ: begin
        buffer_enable_n  = 1'b0;
        buffer_direction = 1'b0;
      end
      ebi_pkg::EBI_BUF_WRITE: begin
        buffer_enable_n  = 1'b0;
        buffer_direction = 1'b1;
      end
      ebi_pkg::EBI_BUF_OFF: begin
        buffer_enable_n  = 1'b1;
        buffer_direction = 1'b0;
      end
      default: begin
        buffer_enable_n  = 1'b1;
        buffer_direction = 1'b0;
      end
    endcase
  end

  // Read strobe for ROM and system-bus reads.
  assign rd_strobe_nxt = ~((is_rom || is_bus) && !req.write);
  // Write strobe for ROM, DRAM and system-bus writes.
  assign wr_strobe_nxt = ~((is_rom || is_bus || is_dram) && req.write);

  // ROM is half-word wide, so it drops the byte address bit.
  assign addr_nxt = is_rom
    ? req.addr[ebi_pkg::EBI_ROM_ADDR_LSB +: ebi_pkg::EBI_PIN_ADDR_W]
    : req.addr[ebi_pkg::EBI_STD_ADDR_LSB +: ebi_pkg::EBI_PIN_ADDR_W];

  // Four active-low ROM bank selects.
  assign rom_sel_nxt = rom_onehot_n(is_rom, req.rom_bank);

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_strobe_r <= ebi_pkg::EBI_STROBE_IDLE;
      wr_strobe_r <= ebi_pkg::EBI_STROBE_IDLE;
      addr_r      <= ebi_pkg::EBI_ADDR_RST[21:0];
      rom_sel_r   <= {ROM_BANKS{ebi_pkg::EBI_STROBE_IDLE}};
      gpio_in_r   <= '0;
    end else begin
      rd_strobe_r <= rd_strobe_nxt;
      wr_strobe_r <= wr_strobe_nxt;
      addr_r      <= addr_nxt;
      rom_sel_r   <= rom_sel_nxt;
      gpio_in_r   <= gpio_in_nxt;
    end
  end

  assign mem_read_strobe_n  = rd_strobe_r;
  assign mem_write_strobe_n = wr_strobe_r;
  assign addr_pins          = addr_r;
  // The pin levels come from the board, outside the clock domain. A bit is
  // only taken once the second and third stages agree, so a level caught
  // while it moves is never reported; the price is four cycles of delay.
  always_ff @(posedge clk) begin
    if (srst) begin
      gpio_sync1_r <= '0;
      gpio_sync2_r <= '0;
      gpio_sync3_r <= '0;
    end else begin
      gpio_sync1_r <= rom_bank_select_in;
      gpio_sync2_r <= gpio_sync1_r;
      gpio_sync3_r <= gpio_sync2_r;
    end
  end

  assign gpio_agree  = ~(gpio_sync2_r ^ gpio_sync3_r);
  assign gpio_in_nxt = (gpio_agree & gpio_sync3_r) | (~gpio_agree & gpio_in_r);

  assign gpio_in            = gpio_in_r;

  // Banks 0..2 share their pins with GPIO; in GPIO mode the pin carries
  // the GPIO level and is only driven when GPIO asks for it. Bank 3 has
  // no alternative role and is always driven.
  genvar g;
  generate
    for (g = 0; g < GPIO_BANKS; g++) begin : gen_shared
      assign rom_bank_select_n[g]    = rom_gpio_mode[g] ? gpio_out[g]
                                                        : rom_sel_r[g];
      assign rom_bank_select_oe_n[g] = rom_gpio_mode[g] ? ~gpio_drive[g]
                                                        : 1'b0;
    end
    for (g = GPIO_BANKS; g < ROM_BANKS; g++) begin : gen_dedicated
      assign rom_bank_select_n[g]    = rom_sel_r[g];
      assign rom_bank_select_oe_n[g] = 1'b0;
    end
  endgenerate

  // SDRAM/EDO pin roles from one memory-type setting.
  ebi_strobe_mux u_strobe_mux (
    .clk        (clk),
    .srst       (srst),
    .mem_is_edo (mem_is_edo),
    .sdram      (sdram),
    .edo        (edo),
    .pins       (mem_pins)
  );

  assign sdram_bank_select_n = mem_pins.bank_select_n;
  assign sdram_col_strobe_n  = mem_pins.col_strobe_n;
  assign sdram_row_strobe_n  = mem_pins.row_strobe_n;
  assign upper_byte_mask     = mem_pins.upper_byte;
  assign lower_byte_mask     = mem_pins.lower_byte;
  assign memory_clock_gate   = mem_pins.clock_gate;

  // The run flag changes on the falling edge, while clk is low, so the
  // gated clock never shows a runt pulse. It costs a half-cycle of
  // latency, which the sequencer must allow for when it asks for a run.
  always_ff @(negedge clk) begin
    if (srst) begin
      clk_run_r <= 1'b0;
    end else begin
      clk_run_r <= sdram.clk_run && !mem_is_edo;
    end
  end

  // Memory clock at the bus clock rate, only during SDRAM access.
  assign memory_clock_out = clk && clk_run_r;

endmodule : ebi_ctrl

`default_nettype wire

// ### src/ebi_pkg.sv
package ebi_pkg;

  // Kinds of external cycle that the bus controller can request.
  typedef enum logic [2:0] {
    EBI_ACC_NONE = 3'b000,
    EBI_ACC_ROM  = 3'b001,
    EBI_ACC_ISA  = 3'b010,
    EBI_ACC_CARD = 3'b011,
    EBI_ACC_DRAM = 3'b100
  } ebi_acc_type;

  // States of the isolation buffer control.
  typedef enum logic [1:0] {
    EBI_BUF_GATED = 2'b00,
    EBI_BUF_OFF   = 2'b01,
    EBI_BUF_READ  = 2'b10,
    EBI_BUF_WRITE = 2'b11
  } ebi_buf_type;

  localparam int          EBI_ADDR_W       = 23;
  localparam int          EBI_PIN_ADDR_W   = 22;
  localparam int          EBI_ROM_BANKS    = 4;
  localparam int          EBI_GPIO_BANKS   = 3;
  localparam int          EBI_DRAM_BANKS   = 2;
  // A ROM cycle drops the byte bit: internal bits 22..1 go out.
  localparam int          EBI_ROM_ADDR_LSB = 1;
  localparam int          EBI_STD_ADDR_LSB = 0;
  localparam logic        EBI_BUF_EN_RST   = 1'b0;
  localparam logic        EBI_BUF_DIR_RST  = 1'b0;
  localparam logic        EBI_STROBE_IDLE  = 1'b1;
  localparam logic [22:0] EBI_ADDR_RST     = 23'h000000;

  // One external cycle request from the bus controller.
  typedef struct packed {
    ebi_acc_type kind;
    logic        write;
    logic        hibernate;
    logic [1:0]  rom_bank;
    logic [22:0] addr;
  } ebi_req_type;

  // Strobes that the SDRAM sequencer wants on the pins.
  typedef struct packed {
    logic [1:0] cs_n;
    logic       ras_n;
    logic       cas_n;
    logic [1:0] dqm;
    logic       cke;
    logic       clk_run;
  } ebi_sdram_type;

  // Strobes that the EDO DRAM sequencer wants on the pins.
  typedef struct packed {
    logic [1:0] ras_n;
    logic       upper_column_strobe_n_n;
    logic       lower_column_strobe_n_n;
  } ebi_edo_type;

  // Shared memory pins after role selection.
  typedef struct packed {
    logic [1:0] bank_select_n;
    logic       col_strobe_n;
    logic       row_strobe_n;
    logic       upper_byte;
    logic       lower_byte;
    logic       clock_gate;
  } ebi_mem_pins_type;

endpackage : ebi_pkg

// ### src/ebi_strobe_mux.sv
`timescale 1ns/1ps
`default_nettype none

module ebi_strobe_mux (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      mem_is_edo,
  input  wire ebi_pkg::ebi_sdram_type    sdram,
  input  wire ebi_pkg::ebi_edo_type      edo,
  output ebi_pkg::ebi_mem_pins_type      pins
);

  ebi_pkg::ebi_mem_pins_type pins_r;
  ebi_pkg::ebi_mem_pins_type pins_nxt;
  ebi_pkg::ebi_mem_pins_type idle_pins;

  assign idle_pins = '{
    bank_select_n: {ebi_pkg::EBI_DRAM_BANKS{ebi_pkg::EBI_STROBE_IDLE}},
    col_strobe_n:  ebi_pkg::EBI_STROBE_IDLE,
    row_strobe_n:  ebi_pkg::EBI_STROBE_IDLE,
    upper_byte:    ebi_pkg::EBI_STROBE_IDLE,
    lower_byte:    ebi_pkg::EBI_STROBE_IDLE,
    clock_gate:    1'b0
  };

  // One memory-type setting steers every shared strobe at once, so the
  // pins can never show a mix of SDRAM and EDO roles.
  // Bank selects: SDRAM chip selects or EDO row strobes.
  assign pins_nxt.bank_select_n = mem_is_edo ? edo.ras_n : sdram.cs_n;
  // The SDRAM command strobes rest inactive when EDO is fitted.
  assign pins_nxt.col_strobe_n  = mem_is_edo ? ebi_pkg::EBI_STROBE_IDLE
                                             : sdram.cas_n;
  assign pins_nxt.row_strobe_n  = mem_is_edo ? ebi_pkg::EBI_STROBE_IDLE
                                             : sdram.ras_n;
  // Byte lanes: SDRAM byte masks or EDO column strobes.
  assign pins_nxt.upper_byte    = mem_is_edo ? edo.upper_column_strobe_n_n : sdram.dqm[1];
  assign pins_nxt.lower_byte    = mem_is_edo ? edo.lower_column_strobe_n_n : sdram.dqm[0];
  // Clock enable serves as the memory's CKE input.
  assign pins_nxt.clock_gate    = mem_is_edo ? 1'b0 : sdram.cke;

  always_ff @(posedge clk) begin
    if (srst) begin
      pins_r <= idle_pins;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins = pins_r;

endmodule : ebi_strobe_mux

`default_nettype wire

// ### tb/ebi_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Board side of the shared ROM select pins. A released pin rises through its
// pull-up, so a read-back never sees a stale driven value.
module ebi_far_side (
  input  wire logic [3:0] select_n,
  input  wire logic [3:0] select_oe_n,
  output logic [2:0]      pin_level
);
  assign pin_level = select_n[2:0] | select_oe_n[2:0];
endmodule : ebi_far_side

`default_nettype wire

// ### tb/ebi_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module ebi_ctrl_checker (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   req_valid,
  input wire ebi_pkg::ebi_req_type   req,
  input wire logic                   ext_buffer_gate_bit,
  input wire logic                   mem_is_edo,
  input wire ebi_pkg::ebi_sdram_type sdram,
  input wire ebi_pkg::ebi_edo_type   edo,
  input wire logic                   buffer_enable_n,
  input wire logic                   buffer_direction,
  input wire logic                   mem_read_strobe_n,
  input wire logic                   mem_write_strobe_n,
  input wire logic [21:0]            addr_pins,
  input wire logic [1:0]             sdram_bank_select_n,
  input wire logic                   sdram_col_strobe_n,
  input wire logic                   upper_byte_mask,
  input wire logic                   memory_clock_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire slow_cycle = req_valid && !req.hibernate && req.kind inside
    {ebi_pkg::EBI_ACC_ROM, ebi_pkg::EBI_ACC_ISA, ebi_pkg::EBI_ACC_CARD};
  wire open_gate = !ext_buffer_gate_bit;

  a_gate_holds_low: assert property (ext_buffer_gate_bit |=>
    !buffer_enable_n && !buffer_direction) else $error("gated buffer pins");
  a_read_buffer: assert property (open_gate && slow_cycle && !req.write
    |=> !buffer_enable_n && !buffer_direction) else $error("read buffer");
  a_write_buffer: assert property (open_gate && slow_cycle && req.write
    |=> !buffer_enable_n && buffer_direction) else $error("write buffer");
  a_buffer_off: assert property (open_gate && req_valid &&
    (req.kind == ebi_pkg::EBI_ACC_DRAM || req.hibernate) |=> buffer_enable_n)
    else $error("buffer not off");
  a_idle_buffer: assert property (open_gate && !req_valid |=>
    buffer_enable_n) else $error("idle buffer enabled");
  a_read_strobe: assert property (slow_cycle && !req.write |=>
    !mem_read_strobe_n) else $error("read strobe");
  a_write_strobe: assert property (req_valid && req.write && !req.hibernate
    && req.kind != ebi_pkg::EBI_ACC_NONE |=> !mem_write_strobe_n)
    else $error("write strobe");
  a_addr_pins: assert property (req_valid |=> addr_pins ==
    (($past(req.kind) == ebi_pkg::EBI_ACC_ROM) ? $past(req.addr[22:1])
    : $past(req.addr[21:0]))) else $error("address pins");
  a_edo_quiet: assert property (mem_is_edo |=> sdram_col_strobe_n &&
    !memory_clock_gate) else $error("sdram pins in edo mode");
  a_shared_roles: assert property (1'b1 |=>
    sdram_bank_select_n == ($past(mem_is_edo) ? $past(edo.ras_n)
    : $past(sdram.cs_n)) && upper_byte_mask == ($past(mem_is_edo)
    ? $past(edo.upper_column_strobe_n_n) : $past(sdram.dqm[1]))) else $error("shared roles");
endmodule : ebi_ctrl_checker

bind ebi_ctrl ebi_ctrl_checker u_chk (.clk, .srst, .req_valid, .req,
  .ext_buffer_gate_bit, .mem_is_edo, .sdram, .edo, .buffer_enable_n,
  .buffer_direction, .mem_read_strobe_n, .mem_write_strobe_n, .addr_pins,
  .sdram_bank_select_n, .sdram_col_strobe_n, .upper_byte_mask,
  .memory_clock_gate);

`default_nettype wire

// ### tb/tb_ebi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ebi_ctrl;
  logic                   clk, srst, req_valid, gate, mem_is_edo;
  ebi_pkg::ebi_req_type   req;
  ebi_pkg::ebi_sdram_type sdram;
  ebi_pkg::ebi_edo_type   edo;
  logic [2:0]             gpio_mode, gpio_out, gpio_drive, pins, gpio_in;
  logic [3:0]             sel_n, sel_oe_n;
  logic [21:0]            addr_pins;
  logic [1:0]             bank_n;
  logic                   en_n, dir, rd_n, wr_n, col_n, row_n;
  logic                   ubm, lbm, cke, mclk;
  int                     n_errors, n_compared;

  ebi_ctrl uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .ext_buffer_gate_bit(gate), .mem_is_edo(mem_is_edo), .sdram(sdram),
    .edo(edo), .rom_gpio_mode(gpio_mode), .gpio_out(gpio_out),
    .gpio_drive(gpio_drive), .rom_bank_select_in(pins), .gpio_in(gpio_in),
    .buffer_enable_n(en_n), .buffer_direction(dir),
    .rom_bank_select_n(sel_n), .rom_bank_select_oe_n(sel_oe_n),
    .mem_read_strobe_n(rd_n), .mem_write_strobe_n(wr_n),
    .addr_pins(addr_pins), .sdram_bank_select_n(bank_n),
    .sdram_col_strobe_n(col_n), .sdram_row_strobe_n(row_n),
    .upper_byte_mask(ubm), .lower_byte_mask(lbm), .memory_clock_gate(cke),
    .memory_clock_out(mclk));
  ebi_far_side u_far (.select_n(sel_n), .select_oe_n(sel_oe_n),
    .pin_level(pins));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Outputs are registered, so the effect is looked at one edge later.
  task automatic cycle(ebi_pkg::ebi_acc_type k, logic w, logic h,
                       logic [1:0] b, logic [22:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{k, w, h, b, a};
    @(posedge clk);
    #1;
  endtask : cycle

  task automatic t_gated();
    cycle(ebi_pkg::EBI_ACC_ISA, 1'b1, 1'b0, 2'h0, 23'h000000);
    check("gated", {en_n, dir}, 2'h0);
    @(posedge clk);
    gate <= 1'b0;
  endtask : t_gated

  task automatic t_slow();
    for (int k = 1; k <= 3; k++) begin
      for (int w = 0; w <= 1; w++) begin
        cycle(ebi_pkg::ebi_acc_type'(k), w[0], 1'b0, 2'h3, 23'h000000);
        check("enable", en_n, 1'b0);
        check("direction", dir, w[0]);
        check("read strobe", rd_n, w[0]);
        check("write strobe", wr_n, !w[0]);
      end
    end
  endtask : t_slow

  task automatic t_off();
    cycle(ebi_pkg::EBI_ACC_DRAM, 1'b1, 1'b0, 2'h0, 23'h000000);
    check("dram", {en_n, wr_n}, 2'h2);
    cycle(ebi_pkg::EBI_ACC_ROM, 1'b0, 1'b1, 2'h0, 23'h000000);
    check("hibernate", en_n, 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    #1;
    check("idle", {en_n, rd_n}, 2'h3);
  endtask : t_off

  task automatic t_addr();
    cycle(ebi_pkg::EBI_ACC_ROM, 1'b0, 1'b0, 2'h0, 23'h6aaaab);
    check("rom address", addr_pins, 22'h355555);
    cycle(ebi_pkg::EBI_ACC_ISA, 1'b0, 1'b0, 2'h0, 23'h6aaaab);
    check("isa address", addr_pins, 22'h2aaaab);
  endtask : t_addr

  task automatic t_rom_sel();
    for (int b = 0; b < 4; b++) begin
      cycle(ebi_pkg::EBI_ACC_ROM, 1'b0, 1'b0, b[1:0], 23'h000000);
      check("rom select", {sel_n, sel_oe_n}, {~(4'h1 << b), 4'h0});
    end
    @(posedge clk);
    gpio_mode <= 3'h7;
    gpio_drive <= 3'h5;
    gpio_out <= 3'h1;
    // The read-back passes a three-stage synchroniser before it counts.
    repeat (4) @(posedge clk);
    #1;
    check("gpio enables", sel_oe_n, 4'h2);
    check("gpio readback", gpio_in, 3'h3);
  endtask : t_rom_sel

  task automatic t_roles();
    @(posedge clk);
    sdram <= '{2'b10, 1'b0, 1'b1, 2'b01, 1'b1, 1'b1};
    edo <= '{2'b01, 1'b1, 1'b0};
    repeat (3) @(posedge clk);
    #1;
    check("sdram pins", {bank_n, col_n, row_n, ubm, lbm, cke}, 7'h53);
    check("clock runs", mclk, 1'b1);
    @(posedge clk);
    mem_is_edo <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("edo pins", {bank_n, col_n, row_n, ubm, lbm, cke, mclk}, 8'h78);
    @(posedge clk);
    mem_is_edo <= 1'b0;
    sdram.clk_run <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("clock stopped", mclk, 1'b0);
  endtask : t_roles

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    srst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    gate = 1'b1;
    mem_is_edo = 1'b0;
    sdram = '1;
    edo = '1;
    gpio_mode = 3'h0;
    gpio_out = 3'h0;
    gpio_drive = 3'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    check("after reset", {en_n, dir}, 2'h0);
    t_gated();
    t_slow();
    t_off();
    t_addr();
    t_rom_sel();
    t_roles();
    finish_test();
  end
endmodule : tb_ebi_ctrl

`default_nettype wire
